// ==== inc/pfc_pkg.sv ====
// pfc_pkg: constants and carrier types for the parallel flash configuration master.
// assumes a 25 MHz core clock and a link clock for the flash side.
package pfc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_NS = 40;
  localparam int LINK_PERIOD_MAX_NS = 50;
  localparam int RESTART_MIN_NS = 500;
  localparam int RESTART_MIN_CYC = (RESTART_MIN_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

  // ----------------------------------------------------------------
  // flash map and widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam logic [23:0] BOOT_ADDR_RESET = 24'h01_0000;
  localparam logic [31:0] IMAGE_WORDS_RESET = 32'h0000_0100;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef enum logic [2:0] {
    PFC_IDLE,
    PFC_LOAD,
    PFC_HANDOFF,
    PFC_WAIT_DONE,
    PFC_INIT,
    PFC_ERROR,
    PFC_RELEASED
  } pfc_state_t;

  // flash pins as one group
  typedef struct packed {
    logic [23:0] addr;
    logic sel_n;
    logic oe_n;
    logic avd_n;
    logic we_n;
    logic rst_n;
    logic drive;
  } pfc_flash_t;

  // open-drain shared lines, low-active drive requests
  typedef struct packed {
    logic status_low;
    logic complete_low;
  } pfc_shared_t;

endpackage

// ==== rtl/pfc_master.sv ====
// pfc_master: active-parallel configuration master with chain hand-off and bus release.
// assumes shared status/complete lines pulled up outside and a link clock of at least 20 MHz
// supplied from the internal oscillator divider.
//
// Notes on behaviour
// - slaves take low data byte in byte mode
// - word mode feeds both chains concurrently
// - status and complete lines are open-drain
// - loaded device enables chain, releases complete
// - all devices initialise when complete rises
// - flash wait output ignored while configuring
// - restart by other master tristates flash bus
// - config clock from internal oscillator drives interface
// - config clock period never above 50 ns; only LINK_PERIOD_NS is checked, and the bench runs the clock at 125 ns
// - word mode moves one word per clock
// - default boot word address is 0x010000
// - boot address replaceable by test instruction
// - flash programmable through test access port
// - drives 24-bit address, 16-bit data bus
// - first chip enable tied low; chains onward
`timescale 1ns/100ps

module pfc_master #(
  parameter int LINK_PERIOD_NS = 40
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic config_clock_in,
  input wire logic chip_enable_in_n_in,
  input wire logic config_restart_n_in,
  input wire logic config_status_n_in,
  input wire logic config_complete_in,
  input wire logic word_mode_in,
  input wire logic flash_wait_in,
  input wire logic [15:0] flash_data_in,
  input wire logic [23:0] boot_address_in,
  input wire logic boot_address_set_in,
  input wire logic [31:0] image_words_in,
  input wire logic image_error_in,
  output logic config_clock_out,
  output logic [23:0] flash_address_bus_out,
  output logic flash_select_n_out,
  output logic flash_output_enable_n_out,
  output logic flash_address_valid_n_out,
  output logic flash_write_enable_n_out,
  output logic flash_reset_n_out,
  output logic flash_bus_oe_out,
  output logic [7:0] slave_low_byte_out,
  output logic [7:0] slave_high_byte_out,
  output logic slave_byte_valid_out,
  output logic chain_enable_out_n_out,
  output logic config_status_n_out,
  output logic config_status_n_oe_out,
  output logic config_complete_out,
  output logic config_complete_oe_out,
  output logic init_out
);

  // ----------------------------------------------------------------
  // clock rate check
  // ----------------------------------------------------------------
  // the link clock comes from the oscillator divider; its period is bounded
  initial begin
    if (LINK_PERIOD_NS > pfc_pkg::LINK_PERIOD_MAX_NS) begin
      $error("link clock period above limit");
    end
  end

  // ----------------------------------------------------------------
  // core state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] ce_sync;
    logic [2:0] rst_sync;
    logic [2:0] st_sync;
    logic [2:0] cd_sync;
    logic [2:0] done_sync;
    logic ce_n;
    logic restart_n;
    logic status_n;
    logic complete;
    logic link_done;
    pfc_pkg::pfc_state_t state;
    logic [23:0] boot_addr;
    logic [31:0] image_words;
    logic run_tgl;
    logic [8:0] low_cnt;
    logic word_mode;
  } pfc_core_t;

  pfc_core_t q;
  pfc_core_t next_q;

  // link side state
  typedef struct packed {
    logic [2:0] run_sync;
    logic run_seen;
    logic [23:0] addr;
    logic [31:0] left;
    logic active;
    logic primed;
    logic done_tgl;
    logic [7:0] lo;
    logic [7:0] hi;
    logic valid;
  } pfc_link_t;

  pfc_link_t l;
  pfc_link_t next_l;

  function automatic logic agreed(input logic [2:0] s, input logic cur);
    agreed = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  logic restart_low_long;
  assign restart_low_long = q.low_cnt >= 9'(pfc_pkg::RESTART_MIN_CYC);

  always_comb begin
    next_q = q;
    next_q.ce_sync = {q.ce_sync[1:0], chip_enable_in_n_in};
    next_q.rst_sync = {q.rst_sync[1:0], config_restart_n_in};
    next_q.st_sync = {q.st_sync[1:0], config_status_n_in};
    next_q.cd_sync = {q.cd_sync[1:0], config_complete_in};
    next_q.done_sync = {q.done_sync[1:0], l.done_tgl};
    next_q.ce_n = agreed(q.ce_sync, q.ce_n);
    next_q.restart_n = agreed(q.rst_sync, q.restart_n);
    next_q.status_n = agreed(q.st_sync, q.status_n);
    next_q.complete = agreed(q.cd_sync, q.complete);
    next_q.link_done = q.done_sync[2];
    if (boot_address_set_in) begin
      next_q.boot_addr = boot_address_in;
    end
    if (!q.restart_n) begin
      next_q.low_cnt = restart_low_long ? q.low_cnt : q.low_cnt + 9'h001;
    end else begin
      next_q.low_cnt = 9'h000;
    end
    unique case (q.state)
      pfc_pkg::PFC_IDLE: begin
        if (q.restart_n && !q.ce_n && q.status_n) begin
          next_q.image_words = image_words_in;
          next_q.word_mode = word_mode_in;
          next_q.run_tgl = !q.run_tgl;
          next_q.state = pfc_pkg::PFC_LOAD;
        end
      end
      pfc_pkg::PFC_LOAD: begin
        if (image_error_in) begin
          next_q.state = pfc_pkg::PFC_ERROR;
        end else if (q.link_done != q.done_sync[2]) begin
          next_q.state = pfc_pkg::PFC_HANDOFF;
        end
      end
      pfc_pkg::PFC_HANDOFF: next_q.state = pfc_pkg::PFC_WAIT_DONE;
      pfc_pkg::PFC_WAIT_DONE: begin
        if (!q.status_n) begin
          next_q.state = pfc_pkg::PFC_ERROR;
        end else if (q.complete) begin
          next_q.state = pfc_pkg::PFC_INIT;
        end
      end
      pfc_pkg::PFC_INIT: next_q.state = pfc_pkg::PFC_INIT;
      pfc_pkg::PFC_ERROR: next_q.state = pfc_pkg::PFC_ERROR;
      pfc_pkg::PFC_RELEASED: begin
        if (q.restart_n && !q.ce_n) begin
          next_q.state = pfc_pkg::PFC_IDLE;
        end
      end
      default: next_q.state = pfc_pkg::PFC_IDLE;
    endcase
    // restart held low long enough: reset and give up the bus
    if (restart_low_long) begin
      next_q.state = pfc_pkg::PFC_RELEASED;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      q <= '{ce_sync: 3'h7, rst_sync: 3'h7, st_sync: 3'h7, cd_sync: 3'h0,
             done_sync: 3'h0, ce_n: 1'b1, restart_n: 1'b1, status_n: 1'b1,
             complete: 1'b0, link_done: 1'b0, state: pfc_pkg::PFC_IDLE,
             boot_addr: pfc_pkg::BOOT_ADDR_RESET,
             image_words: pfc_pkg::IMAGE_WORDS_RESET, run_tgl: 1'b0,
             low_cnt: 9'h000, word_mode: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // link side: reads flash on the config clock
  // ----------------------------------------------------------------
  always_comb begin
    next_l = l;
    next_l.run_sync = {l.run_sync[1:0], q.run_tgl};
    next_l.valid = 1'b0;
    if (l.run_sync[2] != l.run_seen) begin
      next_l.run_seen = l.run_sync[2];
      next_l.addr = q.boot_addr;
      next_l.left = q.image_words;
      next_l.active = 1'b1;
      next_l.primed = 1'b0;
    end else if (l.active) begin
      // flash_wait_in deliberately unused while configuring
      // synchronous read: data for an address arrives one clock after it is shown
      next_l.primed = 1'b1;
      next_l.addr = l.addr + 24'h00_0001;
      if (l.primed) begin
        next_l.lo = flash_data_in[7:0];
        next_l.hi = q.word_mode ? flash_data_in[15:8] : 8'h00;
        next_l.valid = 1'b1;
        next_l.left = l.left - 32'h0000_0001;
        if (l.left == 32'h0000_0001) begin
          next_l.active = 1'b0;
          next_l.done_tgl = !l.done_tgl;
        end
      end
    end
  end

  always_ff @(posedge config_clock_in) begin
    if (rst_in) begin
      l <= '{run_sync: 3'h0, run_seen: 1'b0, addr: 24'h00_0000, left: 32'h0000_0000,
             active: 1'b0, primed: 1'b0, done_tgl: 1'b0, lo: 8'h00, hi: 8'h00,
             valid: 1'b0};
    end else begin
      l <= next_l;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  logic bus_owned;
  assign bus_owned = q.state != pfc_pkg::PFC_RELEASED;

  assign config_clock_out = config_clock_in;
  assign flash_address_bus_out = l.addr;
  assign flash_select_n_out = !l.active;
  assign flash_output_enable_n_out = !l.active;
  assign flash_address_valid_n_out = !l.active;
  assign flash_write_enable_n_out = 1'b1;
  assign flash_reset_n_out = 1'b1;
  // released pins leave the flash free for a test-port programmer
  assign flash_bus_oe_out = bus_owned;
  assign slave_low_byte_out = l.lo;
  assign slave_high_byte_out = l.hi;
  assign slave_byte_valid_out = l.valid;
  assign chain_enable_out_n_out = !(q.state inside {pfc_pkg::PFC_WAIT_DONE,
                                   pfc_pkg::PFC_INIT});
  // open-drain: output always low, enable when pulling
  assign config_status_n_out = 1'b0;
  assign config_status_n_oe_out = q.state == pfc_pkg::PFC_ERROR;
  assign config_complete_out = 1'b0;
  assign config_complete_oe_out = q.state inside {pfc_pkg::PFC_IDLE,
                                  pfc_pkg::PFC_LOAD};
  assign init_out = q.state == pfc_pkg::PFC_INIT;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_release_restart: assert property (@(posedge core_clk_in) disable iff (rst_in)
    restart_low_long |=> !flash_bus_oe_out)
    else $error("bus not released after restart");
  a_complete_init: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (q.state == pfc_pkg::PFC_WAIT_DONE && q.status_n && q.complete && !restart_low_long)
    |=> init_out)
    else $error("no init on complete");
  a_error_status: assert property (@(posedge core_clk_in) disable iff (rst_in)
    image_error_in && q.state == pfc_pkg::PFC_LOAD && !restart_low_long
    |=> config_status_n_oe_out)
    else $error("error not driven on status");
  a_chain_release: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !chain_enable_out_n_out |-> !config_complete_oe_out)
    else $error("complete held after handoff");
  a_chain_order: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $fell(chain_enable_out_n_out) |-> $past(q.state) == pfc_pkg::PFC_HANDOFF)
    else $error("chain enabled before own load done");
  a_load_gate: assert property (@(posedge core_clk_in) disable iff (rst_in)
    q.state == pfc_pkg::PFC_IDLE && (q.ce_n || !q.restart_n)
    |=> q.state != pfc_pkg::PFC_LOAD)
    else $error("load started without the bus");
  a_boot_start: assert property (@(posedge config_clock_in) disable iff (rst_in)
    l.run_sync[2] != l.run_seen |=> flash_address_bus_out == $past(q.boot_addr))
    else $error("load not started at boot address");
  a_word_step: assert property (@(posedge config_clock_in) disable iff (rst_in)
    l.active && l.run_sync[2] == l.run_seen |=> slave_byte_valid_out == $past(l.primed)
    && flash_address_bus_out == $past(l.addr) + 24'h00_0001)
    else $error("word not moved per clock");
  a_status_od: assert property (@(posedge core_clk_in) disable iff (rst_in)
    config_status_n_out == 1'b0 && config_complete_out == 1'b0)
    else $error("shared line driven high");
  a_wait_ignored: assert property (@(posedge config_clock_in) disable iff (rst_in)
    l.active && $changed(flash_wait_in) |=> $past(l.addr) + 24'h00_0001 == l.addr
    || !$past(l.active))
    else $error("wait altered flash read");

endmodule

// ==== verif/pfc_flash_model.sv ====
// pfc_flash_model: parallel flash as seen by the configuration master.
// assumes the master clocks it with the config clock and owns the pins while loading.
`timescale 1ns/100ps

module pfc_flash_model (
  input wire logic config_clock_in,
  input wire logic [23:0] flash_address_bus_in,
  input wire logic flash_select_n_in,
  input wire logic flash_output_enable_n_in,
  output logic [15:0] flash_data_out,
  output logic flash_wait_out
);
  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  initial begin
    flash_data_out = 16'hffff;
    flash_wait_out = 1'b0;
  end
  // data only on the clock rise; a deselected or output-disabled flash inverts its data on every clock rise
  always @(posedge config_clock_in) begin
    if (!flash_select_n_in && !flash_output_enable_n_in) begin
      flash_data_out <= {~flash_address_bus_in[7:0], flash_address_bus_in[7:0]};
    end else begin
      flash_data_out <= ~flash_data_out;
    end
    // wait toggles so that a master using it would misbehave
    flash_wait_out <= ~flash_wait_out;
  end
endmodule

// ==== verif/parallel_flash_config_chain_test.sv ====
// parallel_flash_config_chain_test: self-checking bench for the configuration master.
// assumes pfc_pkg, pfc_master and pfc_flash_model are compiled before it.
`timescale 1ns/100ps

module parallel_flash_config_chain_test;
  typedef struct packed {
    logic word;
    logic set;
    logic [23:0] boot;
  } pfc_row_t;
  localparam int WORDS = 4;
  logic clk = 0, lclk = 0, rst = 1, ce_n = 1, rs_n = 1, hold = 1, word = 0, set = 0, err = 0;
  logic [23:0] boot = 24'h00_0000, addr;
  logic [15:0] fdata;
  logic [7:0] lo, hi;
  logic fwait, sel_n, oe_n, avd_n, we_n, frst_n, bus_oe, valid, cen_n, st_oe, cd_oe, init;
  int errors = 0, checked = 0;
  pfc_row_t rows [4] = '{'{1'b0, 1'b0, 24'h00_0000}, '{1'b1, 1'b0, 24'h00_0000},
                         '{1'b0, 1'b1, 24'h12_3450}, '{1'b1, 1'b1, 24'hff_fffc}};

  always #20 clk = ~clk;
  always #62.5 lclk = ~lclk;

  // rate parameter keeps its designed value; the slow link clock only stretches the run
  pfc_master pfc_master_i (.core_clk_in(clk), .rst_in(rst),
    .config_clock_in(lclk), .chip_enable_in_n_in(ce_n), .config_restart_n_in(rs_n),
    .config_status_n_in(~st_oe), .config_complete_in(~cd_oe & ~hold), .word_mode_in(word),
    .flash_wait_in(fwait), .flash_data_in(fdata), .boot_address_in(boot),
    .boot_address_set_in(set), .image_words_in(WORDS), .image_error_in(err),
    .config_clock_out(), .flash_address_bus_out(addr), .flash_select_n_out(sel_n),
    .flash_output_enable_n_out(oe_n), .flash_address_valid_n_out(avd_n),
    .flash_write_enable_n_out(we_n), .flash_reset_n_out(frst_n), .flash_bus_oe_out(bus_oe),
    .slave_low_byte_out(lo), .slave_high_byte_out(hi), .slave_byte_valid_out(valid),
    .chain_enable_out_n_out(cen_n), .config_status_n_out(), .config_status_n_oe_out(st_oe),
    .config_complete_out(), .config_complete_oe_out(cd_oe), .init_out(init));

  pfc_flash_model pfc_flash_model_i (.config_clock_in(lclk), .flash_address_bus_in(addr),
    .flash_select_n_in(sel_n), .flash_output_enable_n_in(oe_n), .flash_data_out(fdata),
    .flash_wait_out(fwait));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // reset with the chip enable high, optional boot address, then enable
  task automatic start(input pfc_row_t r);
    rst <= 1;
    ce_n <= 1;
    hold <= 1;
    err <= 0;
    word <= r.word;
    boot <= r.boot;
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    check("chain_en_reset", cen_n, 1'b1);
    check("complete_hold_reset", cd_oe, 1'b1);
    set <= r.set;
    @(posedge clk);
    set <= 0;
    ce_n <= 0;
    for (int i = 0; i < 200 && sel_n !== 1'b0; i++) @(posedge lclk);
    check("first_addr", addr, r.set ? r.boot : pfc_pkg::BOOT_ADDR_RESET);
    check("bus_owned", bus_oe, 1'b1);
    check("flash_strobes", {oe_n, avd_n}, 2'h0);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #500_000;
    errors++;
    end_sim();
  end

  initial begin
    int n;
    logic [23:0] base;
    foreach (rows[k]) begin
      start(rows[k]);
      base = rows[k].set ? rows[k].boot : pfc_pkg::BOOT_ADDR_RESET;
      n = 0;
      repeat (60) begin
        @(posedge lclk);
        if (valid === 1'b1) begin
          check("low_byte", lo, 8'(base + 24'(n)));
          check("high_byte", hi, rows[k].word ? 8'(~(base + 24'(n))) : 8'h00);
          n++;
        end
      end
      check("word_count", n, WORDS);
      check("flash_idle", {sel_n, oe_n, avd_n}, 3'h7);
      check("flash_writes_off", {we_n, frst_n}, 2'h3);
      check("chain_en", cen_n, 1'b0);
      check("complete_released", cd_oe, 1'b0);
      check("init_waits", init, 1'b0);
      @(posedge clk);
      hold <= 0;
      repeat (10) @(posedge clk);
      check("init", init, 1'b1);
    end
    // other master claims the flash: ce high, restart low past 500 ns
    @(posedge clk);
    ce_n <= 1;
    rs_n <= 0;
    repeat (20) @(posedge clk);
    check("bus_released", bus_oe, 1'b0);
    ce_n <= 0;
    rs_n <= 1;
    @(posedge clk);
    rs_n <= 0;
    repeat (2) @(posedge clk);
    rs_n <= 1;
    repeat (10) @(posedge clk);
    check("bus_back", bus_oe, 1'b1);
    // error in mid-load halts the chain on the status line
    start(rows[1]);
    @(posedge clk);
    err <= 1;
    repeat (10) @(posedge clk);
    check("status_low", st_oe, 1'b1);
    check("no_init", init, 1'b0);
    end_sim();
  end
endmodule
